/* common/scl_params.svh */
// Timing figures, counts and fixed values of the serial loader.
// Assumes a 100 MHz reference clock; counts derive from it.
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH
`define SCL_REF_MHZ        100
`define SCL_REF_KHZ        (`SCL_REF_MHZ*1000)
`define SCL_T_CF2ST0_NS    600
`define SCL_CF2ST0_CYC     ((`SCL_T_CF2ST0_NS*`SCL_REF_MHZ)/1000)
`define SCL_T_STATUS_US    268
`define SCL_T_CF2ST1_US    1506
`define SCL_T_CD2UM_MIN_US 175
`define SCL_T_CD2UM_MAX_US 437
`define SCL_CD2UM_MAX_CYC  (`SCL_T_CD2UM_MAX_US*`SCL_REF_MHZ)
`define SCL_INIT_CYCLES    8576
`define SCL_CD2CU_PERIODS  4
`define SCL_CFG_FMAX_MHZ   125
`define SCL_T_CD2CU_NS     ((`SCL_CD2CU_PERIODS*1000)/`SCL_CFG_FMAX_MHZ)
`define SCL_CD2CU_CYC      ((`SCL_T_CD2CU_NS*`SCL_REF_MHZ+999)/1000)
`define SCL_F0_KHZ         12500
`define SCL_F1_KHZ         25000
`define SCL_F2_KHZ         50000
`define SCL_F3_KHZ         100000
`define SCL_CMD_BITS       32
`define SCL_READ_CMD       32'h03000000
`define SCL_WORD_BITS      8
`define SCL_FIFO_DEPTH     8
`endif

/* common/scl_pkg.sv */
// Types shared by the serial loader: states, options and pin groups.
// Assumes scl_params.svh is on the include path.
`include "scl_params.svh"
package scl_pkg;
  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_CLEAR = 3'h1,
    ST_LOAD  = 3'h2,
    ST_DONE  = 3'h3,
    ST_INIT  = 3'h4,
    ST_USER  = 3'h5
  } scl_state_type;
  typedef enum logic [1:0] {
    SRC_OSC     = 2'h0,
    SRC_USER    = 2'h1,
    SRC_CFG_CLK = 2'h2
  } scl_src_type;
  typedef struct packed {
    logic        req_n;
    logic        status_n;
    logic        done;
    logic        cclk;
    logic        sdi;
    logic [3:0]  fdl;
    logic        uclk;
  } scl_pins_type;
  typedef struct packed {
    logic        active_serial_scheme;
    logic        quad;
    scl_src_type src;
    logic [1:0]  rate;
    logic        multi;
    logic        dual_use;
  } scl_strap_type;
  typedef struct packed {
    scl_strap_type strap;
    scl_pins_type  pins;
  } scl_sync_type;
endpackage

/* logic/scl_loader.sv */
// Serial configuration loader: reset handshake, serial intake in the
// passive and active schemes, initialization timing and a word FIFO.
// Assumes every pin is asynchronous to REF_CLK, open-drain lines have
// board pull-ups, and straps are stable from reset onward.
`timescale 1ns/1ps
`include "scl_params.svh"

// ==========================================================================
// Word FIFO with registered output
module scl_fifo #(
  parameter int W = `SCL_WORD_BITS,
  parameter int D = `SCL_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid & in_ready;
  wire           pop  = (cnt_q != '0) & (~out_valid | out_ready);

  assign in_ready = (cnt_q != (AW+1)'(D));

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q     <= AW'(rd_q + 1'b1);
        out_data <= mem_q[rd_q];
      end
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      case ({push, pop})
        2'b10:   cnt_q <= (AW+1)'(cnt_q + 1'b1);
        2'b01:   cnt_q <= (AW+1)'(cnt_q - 1'b1);
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_q <= (AW+1)'(D))
    else $error("fifo count beyond depth");
endmodule

// ==========================================================================
// Loader top
module scl_loader #(
  parameter int unsigned POR_CYC        = 1000,
  parameter int unsigned STATUS_LOW_CYC = `SCL_T_STATUS_US*`SCL_REF_MHZ,
  parameter int unsigned INIT_OSC_CYC   = `SCL_T_CD2UM_MIN_US*`SCL_REF_MHZ,
  parameter int unsigned IMAGE_BITS     = 2048
) (
  input  wire logic       REF_CLK,
  input  wire logic       ARST_N,
  input  wire logic       CONFIG_REQ_N,
  input  wire logic       STATUS_N_I,
  output logic            STATUS_N_O,
  output logic            STATUS_N_OE,
  input  wire logic       DONE_I,
  output logic            DONE_O,
  output logic            DONE_OE,
  output logic            INIT_DONE_O,
  output logic            INIT_DONE_OE,
  input  wire logic       CFG_SERIAL_CLOCK_I,
  output logic            CFG_SERIAL_CLOCK_O,
  output logic            CFG_SERIAL_CLOCK_OE,
  input  wire logic       SERIAL_DATA_IN,
  input  wire logic [3:0] FLASH_DATA_LINES,
  output logic            FLASH_COMMAND_OUT,
  output logic            FLASH_SELECT_N,
  input  wire logic       USER_STARTUP_CLOCK,
  input  wire logic       ACTIVE_SERIAL_SCHEME,
  input  wire logic       QUAD_LINES,
  input  wire logic [1:0] INIT_CLOCK_SOURCE,
  input  wire logic [1:0] SERIAL_CLOCK_RATE,
  input  wire logic       MULTI_DEVICE,
  input  wire logic       DUAL_USE_EN,
  output logic      [7:0] CFG_WORD,
  output logic            CFG_WORD_VALID,
  input  wire logic       CFG_WORD_READY,
  output logic            USER_MODE,
  output logic            USER_PIN_IN
);
  import scl_pkg::*;
  localparam int SW = $bits(scl_sync_type);

  // Clock divider half period for the active scheme; the fastest rate
  // cannot exceed half of REF_CLK, and in chains falls back one step.
  function automatic logic [2:0] half_period(input logic [1:0] rate,
                                             input logic multi);
    int f;
    logic [1:0] r;
    r = (rate == 2'h3 && multi) ? 2'h2 : rate;
    case (r)
      2'h0:    f = `SCL_F0_KHZ;
      2'h1:    f = `SCL_F1_KHZ;
      2'h2:    f = `SCL_F2_KHZ;
      default: f = `SCL_F3_KHZ;
    endcase
    return 3'((`SCL_REF_KHZ + 2*f - 1) / (2*f));
  endfunction

  // ========================================================================
  // Pin synchronisers and edge detection
  logic [SW-1:0]  meta_q;
  logic [SW-1:0]  sync_q;
  scl_pins_type   prev_q;
  scl_sync_type   s;
  scl_strap_type  strap_q;
  wire [SW-1:0]   raw = {ACTIVE_SERIAL_SCHEME, QUAD_LINES, INIT_CLOCK_SOURCE,
                         SERIAL_CLOCK_RATE, MULTI_DEVICE, DUAL_USE_EN,
                         CONFIG_REQ_N, STATUS_N_I, DONE_I,
                         CFG_SERIAL_CLOCK_I, SERIAL_DATA_IN,
                         FLASH_DATA_LINES, USER_STARTUP_CLOCK};
  assign s = scl_sync_type'(sync_q);
  wire cclk_rise = s.pins.cclk & ~prev_q.cclk;
  wire cclk_fall = ~s.pins.cclk & prev_q.cclk;
  wire uclk_rise = s.pins.uclk & ~prev_q.uclk;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= s.pins;
    end
  end

  // ========================================================================
  // Control state and shared timer
  scl_state_type state_q;
  scl_state_type state_d;
  logic [17:0]   tmr_q;
  logic [17:0]   tmr_d;
  logic [2:0]    cu_q;
  logic [23:0]   bits_q;
  logic          fifo_rdy;
  logic          push;
  logic          ovf;
  wire active   = strap_q.active_serial_scheme;
  wire src_user = strap_q.src == SRC_USER;
  wire src_cfg  = strap_q.src == SRC_CFG_CLK && !active;
  wire src_osc  = !src_user && !src_cfg;
  wire cu_done  = cu_q == 3'(`SCL_CD2CU_CYC);
  wire img_full = bits_q == 24'(IMAGE_BITS);
  wire rel_ok   = tmr_q >= 18'(STATUS_LOW_CYC - 1) && s.pins.req_n;
  wire req_low  = !s.pins.req_n && state_q inside
                  {ST_LOAD, ST_DONE, ST_INIT, ST_USER};
  wire ext_err  = state_q == ST_LOAD && !s.pins.status_n;
  wire init_tick = src_user ? uclk_rise & cu_done : cclk_rise;
  // A fall seen in the same cycle as done's rise is the last data edge,
  // so start-up falls only count once done was already high before
  wire tmr_inc  = (state_q == ST_POR) ||
                  (state_q == ST_CLEAR && !(&tmr_q)) ||
                  (state_q == ST_DONE && cclk_fall && s.pins.done &&
                   prev_q.done) ||
                  (state_q == ST_INIT && (src_osc || init_tick));
  wire init_last = src_osc ? tmr_q == 18'(INIT_OSC_CYC - 1) :
                   init_tick && tmr_q == 18'(`SCL_INIT_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_q + {17'h0, tmr_inc};
    case (state_q)
      ST_POR: begin
        if (tmr_q == 18'(POR_CYC - 1)) begin
          state_d = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        if (rel_ok && s.pins.status_n) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (ovf || ext_err) begin
          state_d = ST_CLEAR;
        end else if (img_full) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // Passive hosts must give two falls once done is seen high
        if (s.pins.done && (active || tmr_q == 18'h2)) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_last) begin
          state_d = ST_USER;
        end
      end
      ST_USER: state_d = ST_USER;
      default: state_d = ST_CLEAR;
    endcase
    if (req_low) begin
      state_d = ST_CLEAR;
    end
    if (state_d != state_q) begin
      tmr_d = '0;
    end
  end

  // ========================================================================
  // Active scheme clock, command and capture
  logic [2:0] hc_q;
  logic [5:0] cmd_cnt_q;
  logic       sclk_q;
  logic       cmd_out_q;
  wire [2:0]  half     = half_period(strap_q.rate, strap_q.multi);
  wire        run      = state_q == ST_LOAD && active && fifo_rdy && !img_full;
  wire        hc_end   = hc_q == 3'(half - 3'h1);
  wire        tog      = run && hc_end;
  wire        fall_ev  = tog && sclk_q;
  wire        data_ph  = cmd_cnt_q == 6'(`SCL_CMD_BITS);
  wire [31:0] read_cmd = `SCL_READ_CMD;
  wire        in_load  = state_q == ST_LOAD && !img_full;
  wire        bit_ev   = active ? fall_ev && data_ph
                                : in_load && cclk_rise;
  wire        four     = active && strap_q.quad;
  wire [3:0]  nib      = four ? s.pins.fdl :
                         {3'h0, active ? s.pins.fdl[1] : s.pins.sdi};

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hc_q      <= 3'h0;
      sclk_q    <= 1'b0;
      cmd_cnt_q <= 6'h0;
      cmd_out_q <= 1'b0;
    end else begin
      hc_q   <= (run && !hc_end) ? 3'(hc_q + 3'h1) : 3'h0;
      sclk_q <= state_q != ST_LOAD ? 1'b0 : sclk_q ^ tog;
      if (state_q != ST_LOAD) begin
        cmd_cnt_q <= 6'h0;
      end else if (fall_ev && !data_ph) begin
        cmd_cnt_q <= 6'(cmd_cnt_q + 6'h1);
        cmd_out_q <= read_cmd[~cmd_cnt_q[4:0]];
      end
    end
  end

  // ========================================================================
  // Word assembly in arrival order
  logic [7:0] word_q;
  logic [3:0] wcnt_q;
  logic       first_q;
  logic       init_en_q;
  wire [7:0]  word_next = four ? {nib, word_q[7:4]} : {nib[0], word_q[7:1]};
  wire [3:0]  wcnt_next = 4'(wcnt_q + (four ? 4'h4 : 4'h1));
  assign push = bit_ev && wcnt_next == 4'h8;
  // A passive host cannot be stalled, so a full FIFO aborts the load
  assign ovf  = push && !fifo_rdy;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      word_q    <= 8'h00;
      wcnt_q    <= 4'h0;
      bits_q    <= 24'h0;
      first_q   <= 1'b1;
      init_en_q <= 1'b0;
    end else if (state_q == ST_CLEAR) begin
      wcnt_q    <= 4'h0;
      bits_q    <= 24'h0;
      first_q   <= 1'b1;
      init_en_q <= 1'b0;
    end else if (bit_ev && !ovf) begin
      word_q <= word_next;
      wcnt_q <= push ? 4'h0 : wcnt_next;
      bits_q <= 24'(bits_q + (four ? 24'h4 : 24'h1));
      if (push && first_q) begin
        first_q   <= 1'b0;
        init_en_q <= word_next[0];
      end
    end
  end

  scl_fifo #(
    .W (`SCL_WORD_BITS),
    .D (`SCL_FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (word_next),
    .out_valid (CFG_WORD_VALID),
    .out_ready (CFG_WORD_READY),
    .out_data  (CFG_WORD)
  );

  // ========================================================================
  // State register and pin drivers
  wire stat_d = state_d == ST_POR ||
                (state_d == ST_CLEAR && !(state_q == ST_CLEAR && rel_ok));
  wire done_d = state_d inside {ST_POR, ST_CLEAR, ST_LOAD};
  wire ind_d  = init_en_q && state_d inside {ST_LOAD, ST_DONE, ST_INIT};

  assign STATUS_N_O  = 1'b0;
  assign DONE_O      = 1'b0;
  assign INIT_DONE_O = 1'b0;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q             <= ST_POR;
      tmr_q               <= 18'h0;
      cu_q                <= 3'h0;
      strap_q             <= '0;
      STATUS_N_OE         <= 1'b1;
      DONE_OE             <= 1'b1;
      INIT_DONE_OE        <= 1'b0;
      USER_MODE           <= 1'b0;
      USER_PIN_IN         <= 1'b0;
      CFG_SERIAL_CLOCK_O  <= 1'b0;
      CFG_SERIAL_CLOCK_OE <= 1'b0;
      FLASH_COMMAND_OUT   <= 1'b0;
      FLASH_SELECT_N      <= 1'b1;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      if (state_q == ST_POR) begin
        strap_q <= s.strap;
      end
      cu_q <= state_q != ST_INIT ? 3'h0 :
              cu_done ? cu_q : 3'(cu_q + 3'h1);
      STATUS_N_OE  <= stat_d;
      DONE_OE      <= done_d;
      INIT_DONE_OE <= ind_d;
      USER_MODE    <= state_d == ST_USER;
      USER_PIN_IN  <= state_d == ST_USER && strap_q.dual_use &&
                      s.pins.sdi;
      CFG_SERIAL_CLOCK_O  <= sclk_q;
      CFG_SERIAL_CLOCK_OE <= active && state_q != ST_POR;
      FLASH_COMMAND_OUT   <= cmd_out_q;
      FLASH_SELECT_N      <= !(active && state_d == ST_LOAD);
    end
  end

  // ========================================================================
  // Checks
  localparam int REQ_LAT = `SCL_CF2ST0_CYC;
  logic [17:0] low_cnt_q;
  logic [17:0] init_cnt_q;
  logic [13:0] tick_cnt_q;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      low_cnt_q  <= 18'h0;
      init_cnt_q <= 18'h0;
      tick_cnt_q <= 14'h0;
    end else begin
      low_cnt_q  <= STATUS_N_OE ? 18'(low_cnt_q + 18'h1) : 18'h0;
      init_cnt_q <= state_q == ST_INIT ? 18'(init_cnt_q + 18'h1) : 18'h0;
      tick_cnt_q <= state_q != ST_INIT ? 14'h0 :
                    14'(tick_cnt_q + {13'h0, init_tick});
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  a_req_status_low: assert property (
    $fell(s.pins.req_n) && req_low |-> ##[1:REQ_LAT] STATUS_N_OE)
    else $error("status not pulled low after request");
  a_req_done_low: assert property (
    $fell(s.pins.req_n) && req_low |-> ##[1:REQ_LAT] !USER_MODE && DONE_OE)
    else $error("done not pulled low after request");
  a_status_min_low: assert property (
    $fell(STATUS_N_OE) |-> low_cnt_q >= 18'(STATUS_LOW_CYC))
    else $error("status low pulse too short");
  a_done_in_load: assert property (
    state_q == ST_LOAD |-> DONE_OE && !USER_MODE)
    else $error("done released during transfer");
  a_done_image: assert property (
    $fell(DONE_OE) |-> bits_q == 24'(IMAGE_BITS) && wcnt_q == 4'h0)
    else $error("done released before full image");
  a_init_osc_time: assert property (
    $rose(USER_MODE) && src_osc |-> init_cnt_q >= 18'(INIT_OSC_CYC) &&
    init_cnt_q <= 18'(`SCL_CD2UM_MAX_CYC))
    else $error("oscillator init time out of range");
  a_init_ticks: assert property (
    $rose(USER_MODE) && !src_osc |-> tick_cnt_q == 14'(`SCL_INIT_CYCLES))
    else $error("wrong init clock cycle count");
  a_user_clk_wait: assert property (
    state_q == ST_INIT && src_user && init_tick |->
    init_cnt_q >= 18'(`SCL_CD2CU_CYC))
    else $error("user clock counted too early");
  a_init_done_drive: assert property (
    init_en_q && state_q inside {ST_DONE, ST_INIT} |-> INIT_DONE_OE)
    else $error("init-done not driven low");
  a_cmd_on_fall: assert property (
    $changed(cmd_out_q) |-> $fell(sclk_q))
    else $error("command bit changed off a falling edge");
  a_sample_on_fall: assert property (
    active && bit_ev |=> $fell(sclk_q))
    else $error("flash data sampled off a falling edge");

  c_user_mode:   cover property ($rose(USER_MODE));
  c_active_load: cover property (active && push ##1 state_q == ST_LOAD);
  c_overflow:    cover property (ovf);
  c_user_init:   cover property ($rose(USER_MODE) && src_user);
endmodule

/* sim/scl_host_model.sv */
// Passive serial host: pulses the request, waits for status, shifts
// an image out LSB first, then gives the two start-up falling edges.
// Assumes open-drain status and done wires resolved by the bench.
`timescale 1ns/1ps

// ==========================================================================
// Host model
module scl_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [63:0] image,
  input  wire logic        status_w,
  input  wire logic        done_w,
  output logic             req_n,
  output logic             cfg_serial_clock,
  output logic             sdi
);
  initial begin
    req_n = 1'b1;
    cfg_serial_clock  = 1'b0;
    sdi   = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        req_n <= 1'b0;
        repeat (220) @(posedge clk);
        req_n <= 1'b1;
        while (status_w !== 1'b1) @(posedge clk);
        // Monitored status: wait before the first rise
        repeat (200) @(posedge clk);
        for (int i = 0; i < 64; i++) begin
          sdi <= image[i];
          repeat (4) @(posedge clk);
          cfg_serial_clock <= 1'b1;
          repeat (4) @(posedge clk);
          cfg_serial_clock <= 1'b0;
        end
        // Released data line shows the inverse, not a held value
        sdi <= ~image[63];
        while (done_w !== 1'b1) @(posedge clk);
        repeat (2) begin
          repeat (4) @(posedge clk);
          cfg_serial_clock <= 1'b1;
          repeat (4) @(posedge clk);
          cfg_serial_clock <= 1'b0;
        end
        // Clock left driven low afterwards
      end
    end
  end
endmodule

/* sim/tb_serial_config_loader.sv */
// Self-checking bench for the serial loader in the passive scheme.
// Assumes scl_pkg and scl_loader are compiled first; pull-ups modelled.
`timescale 1ns/1ps

// ==========================================================================
// Bench top
module tb_serial_config_loader;
  logic                  ref_clk = 1'b0;
  logic                  arst_n  = 1'b0;
  logic                  go      = 1'b0;
  logic [63:0]           image   = '0;
  logic                  ready   = 1'b0;
  logic                  uclk    = 1'b0;
  scl_pkg::scl_strap_type strap  = scl_pkg::scl_strap_type'(8'h01);
  logic req_n, hdclk, sdi, status_oe, done_oe, init_oe, cfg_serial_clock_o, cfg_serial_clock_oe;
  logic [7:0]            word;
  logic                  word_valid, user_mode, user_pin, flash_sel_n;
  wire                   status_w = ~status_oe;
  wire                   done_w   = ~done_oe;
  wire                   cfg_serial_clock_w   = cfg_serial_clock_oe ? cfg_serial_clock_o : hdclk;
  int                    n_fail   = 0;
  int                    checked  = 0;
  int                    cyc      = 0;

  always #5 ref_clk = ~ref_clk;
  always #20 uclk = ~uclk;

  scl_loader #(.POR_CYC(20), .STATUS_LOW_CYC(40), .INIT_OSC_CYC(40),
    .IMAGE_BITS(64)) dut (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .CONFIG_REQ_N(req_n),
    .STATUS_N_I(status_w), .STATUS_N_O(), .STATUS_N_OE(status_oe),
    .DONE_I(done_w), .DONE_O(), .DONE_OE(done_oe),
    .INIT_DONE_O(), .INIT_DONE_OE(init_oe),
    .CFG_SERIAL_CLOCK_I(cfg_serial_clock_w), .CFG_SERIAL_CLOCK_O(cfg_serial_clock_o),
    .CFG_SERIAL_CLOCK_OE(cfg_serial_clock_oe), .SERIAL_DATA_IN(sdi),
    .FLASH_DATA_LINES(4'hF), .FLASH_COMMAND_OUT(),
    .FLASH_SELECT_N(flash_sel_n),
    .USER_STARTUP_CLOCK(uclk),
    .ACTIVE_SERIAL_SCHEME(strap.active_serial_scheme),
    .QUAD_LINES(strap.quad), .INIT_CLOCK_SOURCE(strap.src),
    .SERIAL_CLOCK_RATE(strap.rate), .MULTI_DEVICE(strap.multi),
    .DUAL_USE_EN(strap.dual_use), .CFG_WORD(word),
    .CFG_WORD_VALID(word_valid), .CFG_WORD_READY(ready),
    .USER_MODE(user_mode), .USER_PIN_IN(user_pin));

  scl_host_model host (
    .clk(ref_clk), .go(go), .image(image), .status_w(status_w),
    .done_w(done_w), .req_n(req_n), .cfg_serial_clock(hdclk), .sdi(sdi));

  // ========================================================================
  // Reporting
  task automatic finish_test;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Three loads, one with 8576 user clock periods of start-up, stay
  // under 40000 cycles; the ceiling leaves slack
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_fail++;
      finish_test();
    end
  end

  // ========================================================================
  // Scenarios
  task automatic t_power_up;
    repeat (4) @(negedge ref_clk);
    chk({status_oe, done_oe, user_mode}, 32'h6);
  endtask

  // Request, full image with the sink stalled, drain, then start-up
  // Start-up bounds are counted in cycles from done going high
  task automatic t_load(input logic [63:0] img, input logic init_en,
                        input int min_cyc, input int max_cyc);
    int n;
    int t_done;
    logic last_init;
    image <= img;
    go    <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    while (req_n !== 1'b0) @(negedge ref_clk);
    n = 0;
    while (!(status_oe === 1'b1 && done_oe === 1'b1 && user_mode === 1'b0))
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(n <= 60, 1);
    while (status_oe === 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= 40 && n <= 150820, 1);
    n = 0;
    while (done_oe === 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= 700, 1);
    chk(n <= 740, 1);
    chk({cfg_serial_clock_oe, flash_sel_n}, 32'h1);
    t_done = cyc;
    for (int k = 0; k < 8; k++) begin
      while (word_valid !== 1'b1) @(negedge ref_clk);
      chk(word, img[8*k +: 8]);
      @(posedge ref_clk);
      ready <= 1'b1;
      @(posedge ref_clk);
      ready <= 1'b0;
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    chk(word_valid, 1'b0);
    last_init = init_oe;
    while (user_mode !== 1'b1) begin
      last_init = init_oe;
      @(negedge ref_clk);
    end
    chk(last_init, init_en);
    chk(cyc - t_done >= min_cyc, 1);
    chk(cyc - t_done <= max_cyc, 1);
    repeat (4) @(negedge ref_clk);
    chk({status_oe, done_oe, init_oe}, 32'h0);
    chk(user_pin, sdi);
  endtask

  // Straps are taken only after reset, so reset again mid-run with the
  // user clock as start-up source; 8576 periods of 40 ns each
  task automatic t_user_clock;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    strap  <= scl_pkg::scl_strap_type'(8'h11);
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_power_up();
    t_load(64'h5A5A_0F0F_3C3C_A5A5, 1'b1, 34304, 34404);
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_power_up();
    t_load(64'h0123_4567_89AB_CDEF, 1'b1, 40, 43700);
    // Second load restarts from user mode, option bit now off
    t_load(64'hFEDC_BA98_7654_3210, 1'b0, 40, 43700);
    t_user_clock();
    finish_test();
  end
endmodule
